/* tcp_pkg.sv */
package tcp_pkg;
    // ===================================================
    // register word indices (byte address divided by four)
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNT = 3'h1;
    localparam logic [2:0] ADDR_COMPARE = 3'h2;
    localparam logic [2:0] ADDR_MASK = 3'h3;
    localparam logic [2:0] ADDR_FLAGS = 3'h4;
    // ===================================================
    // control fields
    localparam int CTRL_FORCE = 7;
    localparam int CTRL_WAVE_LOW = 6;
    localparam int CTRL_OUT_HIGH = 5;
    localparam int CTRL_OUT_LOW = 4;
    localparam int CTRL_WAVE_HIGH = 3;
    localparam int FLAG_OVF = 1;
    localparam int FLAG_MATCH = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    // ===================================================
    // prescaler taps
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PHASE = 2'h1,
        MODE_MATCHCLR = 2'h2,
        MODE_FAST = 2'h3
    } tcp_mode_t;
    typedef enum logic [2:0] {
        CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } tcp_clksel_t;
endpackage // tcp_pkg

/* tcp_timer8.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module tcp_timer8 import tcp_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // cpu side
    input wire logic globalIrqEnable,
    input wire logic overflowVectorAck,
    input wire logic matchVectorAck,
    output logic overflowIrq,
    output logic matchIrq,
    // pins
    input wire logic extCountIn,
    output logic waveformOut,
    output logic waveformConnected
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] count;
        logic [7:0] compare;
        logic [7:0] compareBuf;
        logic [1:0] mask;
        logic [1:0] flags;
        logic countDown;
        logic blockMatch;
        logic wave;
        logic [9:0] prescale;
        logic extSync1;
        logic extSync2;
        logic extLast;
        logic [31:0] rdata;
        logic ack;
        logic waitReq;
        logic ovfIrq;
        logic mIrq;
        logic connected;
    } tcp_state_t;

    tcp_state_t st, next_st;
    tcp_mode_t mode;
    tcp_clksel_t clkSel;
    logic tick, isPwm, access, wrLow;
    logic [7:0] top, cmpActive, wdat;
    logic rawMatch, match, atTop;
    logic [1:0] outMode;

    // ===================================================
    // decode of current settings
    assign mode = tcp_mode_t'({st.control[CTRL_WAVE_HIGH],
                               st.control[CTRL_WAVE_LOW]});
    assign clkSel = tcp_clksel_t'(st.control[2:0]);
    assign outMode = st.control[CTRL_OUT_HIGH:CTRL_OUT_LOW];
    assign isPwm = (mode == MODE_PHASE) || (mode == MODE_FAST);
    assign access = (read || write) && !st.ack;
    assign wrLow = write && !st.ack && byteenable[0];
    assign wdat = writedata[7:0];

    // ===================================================
    // timer tick select; tick is an enable, never a clock
    always_comb begin
        unique case (clkSel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (st.prescale & DIV8_MASK) == DIV8_MASK;
            CS_DIV64: tick = (st.prescale & DIV64_MASK) == DIV64_MASK;
            CS_DIV256: tick = (st.prescale & DIV256_MASK) == DIV256_MASK;
            CS_DIV1024: tick = st.prescale == DIV1024_MASK;
            CS_EXT_FALL: tick = st.extLast && !st.extSync2;
            CS_EXT_RISE: tick = !st.extLast && st.extSync2;
        endcase
    end

    // ===================================================
    // compare and top values
    // buffered compare in pwm modes
    assign cmpActive = isPwm ? st.compareBuf : st.compare;
    assign top = (mode == MODE_MATCHCLR) ? st.compare : CNT_MAX;
    assign rawMatch = st.count == cmpActive;
    // compare at top ignored with upper out bit in pwm
    assign match = rawMatch && !st.blockMatch
        && !(isPwm && outMode[1] && cmpActive == CNT_MAX);
    assign atTop = st.count == top;

    // ===================================================
    // next-state logic
    always_comb begin
        logic ovfEvt;
        logic matchEvt;
        logic [1:0] clr;
        ovfEvt = 1'b0;
        matchEvt = 1'b0;
        clr = 2'b00;
        next_st = st;
        // pin passes two flops before any logic sees it
        next_st.extSync1 = extCountIn;
        next_st.extSync2 = st.extSync1;
        // pin edges counted whatever the pin direction
        next_st.extLast = st.extSync2;
        next_st.prescale = st.prescale + 10'h001;
        if (tick) begin
            next_st.blockMatch = 1'b0;
            if (match) begin
                matchEvt = 1'b1;
                unique case (mode)
                    MODE_NORMAL, MODE_MATCHCLR: begin
                        unique case (outMode)
                            2'b00: next_st.wave = st.wave;
                            2'b01: next_st.wave = !st.wave;
                            2'b10: next_st.wave = 1'b0;
                            2'b11: next_st.wave = 1'b1;
                        endcase
                    end
                    MODE_FAST: begin
                        if (outMode[1])
                            next_st.wave = outMode[0];
                    end
                    MODE_PHASE: begin
                        // phase pwm up and down actions
                        if (outMode[1])
                            next_st.wave = outMode[0] ^ st.countDown;
                    end
                endcase
            end
            unique case (mode)
                MODE_NORMAL: begin
                    next_st.count = st.count + 8'h01;
                    ovfEvt = st.count == CNT_MAX;
                end
                MODE_MATCHCLR: begin
                    next_st.count = atTop ? CNT_BOTTOM : st.count + 8'h01;
                    ovfEvt = st.count == CNT_MAX;
                end
                MODE_FAST: begin
                    next_st.count = st.count + 8'h01;
                    ovfEvt = st.count == CNT_MAX;
                    if (atTop) begin
                        next_st.compareBuf = st.compare;
                        if (outMode[1])
                            next_st.wave = !outMode[0];
                    end
                end
                MODE_PHASE: begin
                    if (atTop) begin
                        next_st.countDown = 1'b1;
                        next_st.compareBuf = st.compare;
                        next_st.count = st.count - 8'h01;
                        // top action for compare at max
                        if (outMode[1] && st.compareBuf == CNT_MAX)
                            next_st.wave = !outMode[0];
                    end else if (st.count == CNT_BOTTOM && st.countDown) begin
                        ovfEvt = 1'b1;
                        next_st.countDown = 1'b0;
                        next_st.count = st.count + 8'h01;
                    end else if (st.countDown) begin
                        next_st.count = st.count - 8'h01;
                    end else begin
                        next_st.count = st.count + 8'h01;
                    end
                end
            endcase
        end
        // ===================================================
        // register writes (one cycle accept, bus waits one)
        if (wrLow) begin
            unique case (address[4:2])
                ADDR_CONTROL: begin
                    next_st.control = {1'b0, wdat[6:0]};
                    // no flag, no irq, no clear from strobe
                    if (wdat[CTRL_FORCE] && !wdat[CTRL_WAVE_LOW]) begin
                        // act on out mode now written
                        unique case (wdat[CTRL_OUT_HIGH:CTRL_OUT_LOW])
                            2'b00: next_st.wave = st.wave;
                            2'b01: next_st.wave = !st.wave;
                            2'b10: next_st.wave = 1'b0;
                            2'b11: next_st.wave = 1'b1;
                        endcase
                    end
                end
                ADDR_COUNT: begin
                    // write blocks match on next tick
                    next_st.count = wdat;
                    next_st.blockMatch = 1'b1;
                end
                ADDR_COMPARE: begin
                    next_st.compare = wdat;
                    if (!isPwm)
                        next_st.compareBuf = wdat;
                end
                ADDR_MASK: next_st.mask = wdat[1:0];
                ADDR_FLAGS: clr = wdat[1:0];
                default: ;
            endcase
        end
        // overflow clear by vector or write one; set wins
        clr[FLAG_OVF] = clr[FLAG_OVF] | overflowVectorAck;
        // match clear by vector or write one; set wins
        clr[FLAG_MATCH] = clr[FLAG_MATCH] | matchVectorAck;
        next_st.flags = (st.flags & ~clr) | {ovfEvt, matchEvt};
        next_st.ovfIrq = globalIrqEnable && st.mask[FLAG_OVF]
            && next_st.flags[FLAG_OVF];
        next_st.mIrq = globalIrqEnable && st.mask[FLAG_MATCH]
            && next_st.flags[FLAG_MATCH];
        // pin override when any out bit set
        // reserved pwm code keeps pin disconnected
        next_st.connected = (outMode != 2'b00)
            && !(isPwm && outMode == 2'b01);
        // ===================================================
        // read data, registered
        next_st.ack = access;
        // kept as its own flop so the port needs no inverter
        next_st.waitReq = !access;
        next_st.rdata = 32'h0000_0000;
        if (read && !st.ack) begin
            unique case (address[4:2])
                ADDR_CONTROL: next_st.rdata[7:0] = st.control;
                ADDR_COUNT: next_st.rdata[7:0] = st.count;
                ADDR_COMPARE: next_st.rdata[7:0] = st.compare;
                ADDR_MASK: next_st.rdata[1:0] = st.mask;
                ADDR_FLAGS: next_st.rdata[1:0] = st.flags;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ===================================================
    // single state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.control <= CTRL_RESET;
            st.waitReq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ===================================================
    // outputs, each from a flop
    assign readdata = st.rdata;
    // waitrequest low only in the answer cycle
    assign waitrequest = st.waitReq;
    assign overflowIrq = st.ovfIrq;
    assign matchIrq = st.mIrq;
    assign waveformOut = st.wave;
    assign waveformConnected = st.connected;
endmodule // tcp_timer8

/* tcp_pin_model.sv */
`timescale 1ns/100ps
module tcp_pin_model (
    // clock
    input wire logic mclk,
    // request from the bench
    input wire logic go,
    input wire logic [3:0] pulses,
    // count pin, pulled low when idle
    output logic extCountIn
);
    // ==========================================
    // pin driver
    // three cycles per half period, so every edge survives the sampler
    // one process owns the pin, idle level included
    initial begin
        extCountIn = 1'b0;
        forever begin
            @(posedge mclk);
            if (go) begin
                repeat (pulses) begin
                    repeat (3) @(posedge mclk);
                    extCountIn <= 1'b1;
                    repeat (3) @(posedge mclk);
                    extCountIn <= 1'b0;
                end
            end
        end
    end
endmodule // tcp_pin_model

/* tcp_timer8_props.sv */
`timescale 1ns/100ps
module tcp_timer8_props import tcp_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // cpu side
    input wire logic globalIrqEnable,
    input wire logic overflowVectorAck,
    input wire logic matchVectorAck,
    input wire logic overflowIrq,
    input wire logic matchIrq,
    // pins
    input wire logic waveformOut,
    input wire logic waveformConnected
);
    // ==========================================
    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic ctlWr;
    // a control write is seen here in the answer cycle, one edge after it lands with waitrequest high
    assign ctlWr = write && !waitrequest && address[4:2] == ADDR_CONTROL;
    AST_ACK_NEXT: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("no answer one cycle after request");
    AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
        else $error("answer held longer than one cycle");
    AST_OVF_GATE: assert property (!globalIrqEnable |=> !overflowIrq)
        else $error("overflow irq without global enable");
    AST_MATCH_GATE: assert property (!globalIrqEnable |=> !matchIrq)
        else $error("match irq without global enable");
    AST_OVF_CLR: assert property (overflowVectorAck |-> ##2 !overflowIrq)
        else $error("overflow irq survives vector ack");
    AST_MATCH_CLR: assert property (matchVectorAck |-> ##2 !matchIrq)
        else $error("match irq survives vector ack");
    AST_FORCE_ZERO: assert property (read && !waitrequest
        && address[4:2] == ADDR_CONTROL |-> !readdata[7])
        else $error("force bit read back as one");
    AST_UNMAPPED: assert property (read && !waitrequest
        && address[4:2] > ADDR_FLAGS |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_FORCE_SET: assert property (ctlWr && writedata[7:4] == 4'hB
        && !writedata[6] |-> ##[1:2] waveformOut)
        else $error("forced set did not reach output");
    AST_DISCONNECT: assert property (ctlWr && (writedata[5:4] == 2'h0
        || (writedata[5:4] == 2'h1 && writedata[6]))
        |-> ##[1:2] !waveformConnected) else $error("output left connected");
    COV_MATCH: cover property (matchIrq);
    COV_OVF: cover property (overflowIrq);
    COV_FORCE: cover property (ctlWr && writedata[7]);
endmodule // tcp_timer8_props
bind tcp_timer8 tcp_timer8_props u_props (.mclk, .rst_n, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .globalIrqEnable,
    .overflowVectorAck, .matchVectorAck, .overflowIrq, .matchIrq,
    .waveformOut, .waveformConnected);

/* tcp_timer8_bench.sv */
`timescale 1ns/100ps
module tcp_timer8_bench import tcp_pkg::*;;
    logic mclk, rst_n, read, write, waitrequest, globalIrqEnable, go;
    logic overflowVectorAck, matchVectorAck, overflowIrq, matchIrq;
    logic extCountIn, waveformOut, waveformConnected;
    logic [4:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable, pulses;
    logic [7:0] q;
    int errCount = 0, checkCount = 0;
    // control writes (force bit set in the first 7), expected level and connection; level skipped from 7 on
    logic [7:0] fv [10] = '{8'hB0, 8'hA0, 8'h90, 8'h90, 8'hB8, 8'hE8,
        8'hE0, 8'h58, 8'h50, 8'h00};
    logic fo [10] = '{1, 0, 1, 0, 1, 1, 1, 1, 1, 1};
    logic fc [10] = '{1, 1, 1, 1, 1, 1, 1, 0, 0, 0};
    int dv [5] = '{1, 8, 64, 256, 1024};
    tcp_timer8 dut (.mclk, .rst_n, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .globalIrqEnable,
        .overflowVectorAck, .matchVectorAck, .overflowIrq, .matchIrq,
        .extCountIn, .waveformOut, .waveformConnected);
    tcp_pin_model pins (.mclk, .go, .pulses, .extCountIn);
    always #10 mclk = ~mclk;
    // ==========================================
    // bus access: hold until waitrequest is seen low, release after
    task automatic acc(input logic w, input logic [2:0] a,
            input logic [7:0] d, output logic [7:0] r);
        int n = 0;
        @(posedge mclk);
        address <= {a, 2'b00};
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        // answer and read data are taken on the rising edge only
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 99);
        r = readdata[7:0];
        if (waitrequest !== 1'b0) errCount++;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
            input logic [7:0] g);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("FAIL %s expected %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] r;
        acc(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e, string nm);
        logic [7:0] r;
        acc(1'b0, a, 8'h00, r);
        chk(nm, e, r);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic completeRun();
        if (errCount == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // watchdog, well above the longest run
    initial begin
        repeat (40000) @(posedge mclk);
        errCount++;
        completeRun();
    end
    // ==========================================
    // tests
    initial begin
        {mclk, rst_n, address, read, write, writedata, go} = '0;
        {globalIrqEnable, overflowVectorAck, matchVectorAck} = '0;
        byteenable = 4'hF;
        pulses = 4'h3;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rc(ADDR_CONTROL, 8'h00, "control");
        rc(ADDR_FLAGS, 8'h00, "flags");
        wr(ADDR_COUNT, 8'h33);
        foreach (fv[i]) begin
            wr(ADDR_CONTROL, fv[i]);
            cyc(2);
            if (i < 7) chk("waveformOut", 8'(fo[i]), 8'(waveformOut));
            chk("connected", 8'(fc[i]), 8'(waveformConnected));
        end
        rc(ADDR_COUNT, 8'h33, "count");
        rc(ADDR_FLAGS, 8'h00, "flags");
        rc(3'h5, 8'h00, "unmapped");
        foreach (dv[i]) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL, 8'(i + 1));
            cyc(8 * dv[i] - 2);
            wr(ADDR_CONTROL, 8'h00);
            acc(1'b0, ADDR_COUNT, 8'h00, q);
            chk("ticks", 8'h1, 8'(q inside {[8'h07:8'h0A]}));
        end
        for (int c = 6; c < 8; c++) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL, 8'(c));
            @(posedge mclk);
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            cyc(30);
            wr(ADDR_CONTROL, 8'h00);
            rc(ADDR_COUNT, 8'h03, "edges");
        end
        wr(ADDR_MASK, 8'h03);
        globalIrqEnable <= 1'b1;
        wr(ADDR_COMPARE, 8'h10);
        wr(ADDR_COUNT, 8'h0C);
        wr(ADDR_CONTROL, 8'h01);
        cyc(8);
        wr(ADDR_CONTROL, 8'h00);
        chk("matchIrq", 8'h1, 8'(matchIrq));
        rc(ADDR_FLAGS, 8'h01, "flags");
        @(posedge mclk);
        matchVectorAck <= 1'b1;
        @(posedge mclk);
        matchVectorAck <= 1'b0;
        cyc(3);
        rc(ADDR_FLAGS, 8'h00, "flags");
        wr(ADDR_COUNT, 8'hFA);
        wr(ADDR_CONTROL, 8'h01);
        cyc(8);
        wr(ADDR_CONTROL, 8'h00);
        chk("overflowIrq", 8'h1, 8'(overflowIrq));
        rc(ADDR_FLAGS, 8'h02, "flags");
        @(posedge mclk);
        overflowVectorAck <= 1'b1;
        @(posedge mclk);
        overflowVectorAck <= 1'b0;
        cyc(3);
        chk("overflowIrq", 8'h0, 8'(overflowIrq));
        wr(ADDR_COUNT, 8'hF0);
        wr(ADDR_CONTROL, 8'h41);
        cyc(40);
        rc(ADDR_FLAGS, 8'h00, "flags");
        cyc(520);
        wr(ADDR_CONTROL, 8'h00);
        rc(ADDR_FLAGS, 8'h03, "flags");
        wr(ADDR_FLAGS, 8'h03);
        rc(ADDR_FLAGS, 8'h00, "flags");
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_COMPARE, 8'h05);
        wr(ADDR_CONTROL, 8'h09);
        cyc(50);
        wr(ADDR_CONTROL, 8'h00);
        acc(1'b0, ADDR_COUNT, 8'h00, q);
        chk("clear at match", 8'h1, 8'(q <= 8'h05));
        // pwm with compare at max: match ignored, top action only
        wr(ADDR_COMPARE, 8'hFF);
        wr(ADDR_CONTROL, 8'h69);
        cyc(300);
        chk("fast level", 8'h1, 8'(waveformOut));
        chk("fast pin", 8'h1, 8'(waveformConnected));
        wr(ADDR_CONTROL, 8'h79);
        cyc(300);
        chk("fast inverted", 8'h0, 8'(waveformOut));
        wr(ADDR_CONTROL, 8'h61);
        cyc(600);
        chk("phase level", 8'h1, 8'(waveformOut));
        wr(ADDR_CONTROL, 8'h00);
        completeRun();
    end
endmodule // tcp_timer8_bench
